/* hdl/crr_result_regs.sv */
`timescale 1ns/10ps
module crr_result_regs #(
  parameter bit WIDE_RESULT = 1'b1
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Two-wire target pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic addr_sel_in,
  // Results from the converter core
  input crr_pkg::crr_result_t [crr_pkg::CRR_NUM_CH-1:0] result_in
);

  crr_pkg::crr_regs_t r;
  crr_pkg::crr_regs_t nxt;
  logic [crr_pkg::CRR_NUM_CH-1:0][15:0] upper_word;
  logic [crr_pkg::CRR_NUM_CH-1:0][15:0] lower_live;

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < crr_pkg::CRR_NUM_CH; g++) begin : g_chan
      always_comb begin
        upper_word[g] = crr_pkg::CRR_WORD_RESET;
        upper_word[g][crr_pkg::CRR_WD_BIT] = r.watchdog_flag[g];
        upper_word[g][crr_pkg::CRR_AW_BIT] = r.amplitude_flag[g];
        if (WIDE_RESULT) begin
          upper_word[g][crr_pkg::CRR_UPPER_DATA_MSB:0] =
            r.result_value[g][crr_pkg::CRR_RES_W-1:crr_pkg::CRR_WIDE_SPLIT];
          lower_live[g] =
            r.result_value[g][crr_pkg::CRR_WIDE_SPLIT-1:0];
        end else begin
          upper_word[g][crr_pkg::CRR_UPPER_DATA_MSB:0] =
            r.result_value[g][crr_pkg::CRR_UPPER_DATA_MSB:0];
          lower_live[g] = crr_pkg::CRR_WORD_RESET;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic load_word;
    logic [7:0] load_ptr;
    logic [1:0] ch;
    logic [15:0] word;
    logic [crr_pkg::CRR_NUM_CH-1:0] clr_wd;
    logic [crr_pkg::CRR_NUM_CH-1:0] clr_aw;
    logic [6:0] my_addr;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_seen = 1'b0;
    stop_seen = 1'b0;
    load_word = 1'b0;
    load_ptr = r.ptr;
    ch = 2'b00;
    word = crr_pkg::CRR_WORD_RESET;
    clr_wd = '0;
    clr_aw = '0;
    my_addr = crr_pkg::CRR_TARGET_ADDR_LOW;
    nxt = r;

    // Stage 0 feeds only stage 1; edges come from stages 1 and 2
    nxt.scl_sync = {r.scl_sync[1:0], scl_in};
    nxt.sda_sync = {r.sda_sync[1:0], sda_in};
    nxt.addr_sync = {r.addr_sync[0], addr_sel_in};
    scl_rise = r.scl_sync[1] & ~r.scl_sync[2];
    scl_fall = ~r.scl_sync[1] & r.scl_sync[2];
    start_seen = r.scl_sync[1] & r.scl_sync[2] &
                 ~r.sda_sync[1] & r.sda_sync[2];
    stop_seen = r.scl_sync[1] & r.scl_sync[2] &
                r.sda_sync[1] & ~r.sda_sync[2];
    if (r.addr_sync[1]) begin
      my_addr = crr_pkg::CRR_TARGET_ADDR_HIGH;
    end

    if (start_seen) begin
      nxt.state = crr_pkg::CRR_ST_ADDR;
      nxt.bit_cnt = 4'h0;
      nxt.sda_oe = 1'b0;
    end else if (stop_seen) begin
      nxt.state = crr_pkg::CRR_ST_IDLE;
      nxt.sda_oe = 1'b0;
    end else begin
      case (r.state)
        crr_pkg::CRR_ST_ADDR, crr_pkg::CRR_ST_PTR,
        crr_pkg::CRR_ST_WR: begin
          if (scl_rise) begin
            nxt.rx_shift = {r.rx_shift[6:0], r.sda_sync[1]};
            nxt.bit_cnt = r.bit_cnt + 4'h1;
          end else if (scl_fall &&
                       r.bit_cnt == crr_pkg::CRR_BITS_PER_BYTE) begin
            nxt.sda_oe = 1'b1;
            if (r.state == crr_pkg::CRR_ST_ADDR) begin
              if (r.rx_shift[7:1] == my_addr) begin
                nxt.read_mode = r.rx_shift[0];
                nxt.state = crr_pkg::CRR_ST_ADDR_ACK;
              end else begin
                nxt.sda_oe = 1'b0;
                nxt.state = crr_pkg::CRR_ST_IDLE;
              end
            end else if (r.state == crr_pkg::CRR_ST_PTR) begin
              nxt.ptr = r.rx_shift;
              nxt.state = crr_pkg::CRR_ST_PTR_ACK;
            end else begin
              // All words here are read-only: data is acked and dropped
              nxt.state = crr_pkg::CRR_ST_WR_ACK;
            end
          end
        end
        crr_pkg::CRR_ST_ADDR_ACK: begin
          if (scl_fall) begin
            nxt.bit_cnt = 4'h0;
            if (r.read_mode) begin
              load_word = 1'b1;
              nxt.state = crr_pkg::CRR_ST_RD;
            end else begin
              nxt.sda_oe = 1'b0;
              nxt.state = crr_pkg::CRR_ST_PTR;
            end
          end
        end
        crr_pkg::CRR_ST_PTR_ACK, crr_pkg::CRR_ST_WR_ACK: begin
          if (scl_fall) begin
            nxt.bit_cnt = 4'h0;
            nxt.sda_oe = 1'b0;
            nxt.state = crr_pkg::CRR_ST_WR;
          end
        end
        crr_pkg::CRR_ST_RD: begin
          if (scl_rise) begin
            nxt.bit_cnt = r.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            nxt.tx_shift = {r.tx_shift[14:0], 1'b0};
            if (r.bit_cnt == crr_pkg::CRR_BITS_PER_BYTE) begin
              nxt.sda_oe = 1'b0;
              nxt.state = crr_pkg::CRR_ST_RD_ACK;
            end else begin
              nxt.sda_oe = ~r.tx_shift[14];
            end
          end
        end
        crr_pkg::CRR_ST_RD_ACK: begin
          if (scl_rise) begin
            nxt.host_nack = r.sda_sync[1];
          end else if (scl_fall) begin
            nxt.bit_cnt = 4'h0;
            if (r.host_nack) begin
              // Host is done; wait for stop or repeated start
              nxt.state = crr_pkg::CRR_ST_IDLE;
            end else if (r.byte_sel) begin
              load_word = 1'b1;
              load_ptr = r.ptr + 8'h01;
              nxt.ptr = load_ptr;
              nxt.state = crr_pkg::CRR_ST_RD;
            end else begin
              nxt.byte_sel = 1'b1;
              nxt.sda_oe = ~r.tx_shift[15];
              nxt.state = crr_pkg::CRR_ST_RD;
            end
          end
        end
        default: begin
          nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // Word fetch; a fetched upper word is the read that clears its flags
    if (load_word) begin
      ch = load_ptr[2:1];
      if (load_ptr <= crr_pkg::CRR_LAST_RESULT_REG) begin
        if (load_ptr[0]) begin
          word = r.lower_hold[ch];
        end else begin
          word = upper_word[ch];
          clr_wd[ch] = 1'b1;
          clr_aw[ch] = 1'b1;
          nxt.lower_hold[ch] = lower_live[ch];
        end
      end
      nxt.tx_shift = word;
      nxt.byte_sel = 1'b0;
      nxt.sda_oe = ~word[15];
    end

    // New results; a flag raised in its clearing cycle survives
    for (int c = 0; c < crr_pkg::CRR_NUM_CH; c++) begin
      nxt.watchdog_flag[c] = (r.watchdog_flag[c] & ~clr_wd[c]) |
        (result_in[c].valid & result_in[c].watchdog_timeout);
      nxt.amplitude_flag[c] = (r.amplitude_flag[c] & ~clr_aw[c]) |
        (result_in[c].valid & result_in[c].amplitude_warning);
      if (result_in[c].valid) begin
        nxt.result_value[c] = result_in[c].value;
      end
    end
    nxt.sda_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= '0;
      r.scl_sync <= 3'b111;
      r.sda_sync <= 3'b111;
      r.state <= crr_pkg::CRR_ST_IDLE;
      for (int c = 0; c < crr_pkg::CRR_NUM_CH; c++) begin
        r.result_value[c] <= crr_pkg::CRR_VALUE_RESET;
        r.lower_hold[c] <= crr_pkg::CRR_WORD_RESET;
      end
    end else begin
      r <= nxt;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_out = r.sda_o;
  assign sda_oe_out = r.sda_oe;

endmodule // crr_result_regs

/* hdl/crr_pkg.sv */
// Overview of operation
// - Upper word bit 13 flags a channel watchdog timeout, cleared by read.
// - Upper word bit 12 flags a channel amplitude warning, cleared by read.
// - Channels 1 to 3 keep own flags at 0x02, 0x04, 0x06 as channel 0 does.
// - Upper bits 15:14 read 0; 11:0 hold the 12-bit result or bits 27:16.
// - Wide variants: the next odd word holds bits 15:0, read-only, reset 0.
package crr_pkg;

  localparam int CRR_NUM_CH = 4;
  localparam int CRR_RES_W = 28;

  // Register offsets (word pointer values)
  localparam logic [7:0] CRR_CH0_RESULT_UPPER = 8'h00;
  localparam logic [7:0] CRR_CH0_RESULT_LOWER = 8'h01;
  localparam logic [7:0] CRR_CH1_RESULT_UPPER = 8'h02;
  localparam logic [7:0] CRR_CH1_RESULT_LOWER = 8'h03;
  localparam logic [7:0] CRR_CH2_RESULT_UPPER = 8'h04;
  localparam logic [7:0] CRR_CH2_RESULT_LOWER = 8'h05;
  localparam logic [7:0] CRR_CH3_RESULT_UPPER = 8'h06;
  localparam logic [7:0] CRR_CH3_RESULT_LOWER = 8'h07;
  localparam logic [7:0] CRR_LAST_RESULT_REG = CRR_CH3_RESULT_LOWER;

  // Upper word field positions
  localparam int CRR_WD_BIT = 13;
  localparam int CRR_AW_BIT = 12;
  localparam int CRR_UPPER_DATA_MSB = 11;
  localparam int CRR_WIDE_SPLIT = 16;

  // Reset values
  localparam logic [15:0] CRR_WORD_RESET = 16'h0000;
  localparam logic [CRR_RES_W-1:0] CRR_VALUE_RESET = 28'h000_0000;

  // Target address: low pin selects the first, high pin the second
  localparam logic [6:0] CRR_TARGET_ADDR_LOW = 7'h2A;
  localparam logic [6:0] CRR_TARGET_ADDR_HIGH = 7'h2B;
  localparam logic [3:0] CRR_BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    CRR_ST_IDLE = 4'b0000,
    CRR_ST_ADDR = 4'b0001,
    CRR_ST_ADDR_ACK = 4'b0010,
    CRR_ST_PTR = 4'b0011,
    CRR_ST_PTR_ACK = 4'b0100,
    CRR_ST_WR = 4'b0101,
    CRR_ST_WR_ACK = 4'b0110,
    CRR_ST_RD = 4'b0111,
    CRR_ST_RD_ACK = 4'b1000
  } crr_state_t;

  // One conversion result from the converter core
  typedef struct packed {
    logic valid;
    logic watchdog_timeout;
    logic amplitude_warning;
    logic [CRR_RES_W-1:0] value;
  } crr_result_t;

  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic [1:0] addr_sync;
    crr_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [15:0] tx_shift;
    logic byte_sel;
    logic read_mode;
    logic host_nack;
    logic [7:0] ptr;
    logic sda_oe;
    logic sda_o;
    logic [CRR_NUM_CH-1:0] watchdog_flag;
    logic [CRR_NUM_CH-1:0] amplitude_flag;
    logic [CRR_NUM_CH-1:0][CRR_RES_W-1:0] result_value;
    logic [CRR_NUM_CH-1:0][15:0] lower_hold;
  } crr_regs_t;

endpackage

/* test/crr_result_regs_monitor.sv */
`timescale 1ns/10ps
module crr_result_regs_monitor (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // Pins and results
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic addr_sel_in,
  input crr_pkg::crr_result_t [crr_pkg::CRR_NUM_CH-1:0] result_in
);
  logic any_valid;
  default clocking @(posedge core_clk_in); endclocking
  always_comb any_valid = result_in[0].valid | result_in[1].valid |
    result_in[2].valid | result_in[3].valid;
  a_drive_low_only: assert property (disable iff (sys_rst_in) !sda_out)
    else $error("sda_out not low");
  a_reset_quiet: assert property (sys_rst_in |-> !sda_oe_out)
    else $error("line pulled in reset");
  a_release_quiet: assert property (disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> !sda_oe_out [*3]) else $error("drive after reset");
  a_rise_scl_low: assert property (disable iff (sys_rst_in)
    $rose(sda_oe_out) |-> !scl_in) else $error("pull while clock high");
  a_fall_scl_low: assert property (disable iff (sys_rst_in)
    $fell(sda_oe_out) |-> !scl_in) else $error("release while clock high");
  a_hold_high: assert property (disable iff (sys_rst_in)
    $rose(scl_in) |=> $stable(sda_oe_out) [*8]) else $error("data moved");
  a_sync_delay: assert property (disable iff (sys_rst_in)
    $fell(scl_in) |=> $stable(sda_oe_out)) else $error("change too early");
  a_result_calm: assert property (disable iff (sys_rst_in)
    any_valid && scl_in |=> $stable(sda_oe_out)) else $error("update glitch");
endmodule // crr_result_regs_monitor

bind crr_result_regs crr_result_regs_monitor crr_result_regs_monitor_inst (
  .core_clk_in, .sys_rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
  .addr_sel_in, .result_in);

/* test/crr_i2c_host.sv */
`timescale 1ns/10ps
module crr_i2c_host (
  // Clock
  input wire logic clk_in,
  // Bus pins
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  localparam int Q = 8;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wt();
    repeat (Q) @(posedge clk_in);
  endtask
  // Data only moves a quarter period after the clock fell
  task automatic bit_io(input logic b, output logic r);
    sda_out <= b;
    wt();
    scl_out <= 1'b1;
    wt();
    r = sda_in;
    wt();
    scl_out <= 1'b0;
    wt();
  endtask
  task automatic start();
    sda_out <= 1'b1;
    wt();
    scl_out <= 1'b1;
    wt();
    sda_out <= 1'b0;
    wt();
    scl_out <= 1'b0;
    wt();
  endtask
  task automatic xfer(input logic [7:0] d, input logic a,
      output logic [7:0] q, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(a, ak);
  endtask
  // Reads n words (1 or 2) from pointer p; a NACK closes the last word
  task automatic rd(input logic [6:0] ta, input logic [7:0] p, input int n,
      output logic [15:0] w0, output logic [15:0] w1, output logic ak);
    logic [7:0] q;
    logic a;
    start();
    xfer({ta, 1'b0}, 1'b1, q, ak);
    xfer(p, 1'b1, q, a);
    start();
    xfer({ta, 1'b1}, 1'b1, q, a);
    xfer(8'hFF, 1'b0, w0[15:8], a);
    xfer(8'hFF, n == 1, w0[7:0], a);
    w1 = 16'h0000;
    if (n > 1) begin
      xfer(8'hFF, 1'b0, w1[15:8], a);
      xfer(8'hFF, 1'b1, w1[7:0], a);
    end
    sda_out <= 1'b0;
    wt();
    scl_out <= 1'b1;
    wt();
    sda_out <= 1'b1;
    wt();
  endtask
endmodule // crr_i2c_host

/* test/crr_result_regs_tb_top.sv */
`timescale 1ns/10ps
module crr_result_regs_tb_top;
  logic core_clk_in, sys_rst_in, addr_sel, scl, host_sda, sda_oe, sda_o, ak;
  logic narrow_on, scl_n, oe_n;
  logic [6:0] ta;
  logic [15:0] w0, w1;
  logic [27:0] v;
  int errors, n_tests;
  crr_pkg::crr_result_t [crr_pkg::CRR_NUM_CH-1:0] res;
  wire sda_wire;
  // Pulled up: low whenever any of the three parties (host, wide target, narrow target) pulls
  assign sda_wire = host_sda & ~sda_oe & ~oe_n;
  // Narrow variant sees a clock only while selected, so it stays silent
  assign scl_n = scl | ~narrow_on;
  crr_result_regs #(.WIDE_RESULT(1'b1)) crr_result_regs_inst (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .addr_sel_in(addr_sel), .result_in(res));
  crr_result_regs #(.WIDE_RESULT(1'b0)) crr_result_regs_narrow_inst (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl_n),
    .sda_in(sda_wire), .sda_out(), .sda_oe_out(oe_n),
    .addr_sel_in(1'b1), .result_in(res));
  crr_i2c_host crr_i2c_host_inst (.clk_in(core_clk_in), .sda_in(sda_wire),
    .scl_out(scl), .sda_out(host_sda));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic get(input logic [7:0] p, input int n);
    crr_i2c_host_inst.rd(ta, p, n, w0, w1, ak);
  endtask
  task pulse(input int c, input logic wd, input logic aw,
      input logic [27:0] val);
    res[c] <= '{valid: 1'b1, watchdog_timeout: wd,
      amplitude_warning: aw, value: val};
    @(posedge core_clk_in);
    res[c].valid <= 1'b0;
    @(posedge core_clk_in);
  endtask
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  initial begin
    #300000;
    errors++;
    wrap_up();
  end
  initial begin
    sys_rst_in = 1'b1;
    addr_sel = 1'b0;
    narrow_on = 1'b0;
    res = '0;
    ta = crr_pkg::CRR_TARGET_ADDR_LOW;
    errors = 0;
    n_tests = 0;
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    for (int c = 0; c < 4; c++) begin
      get(8'(2 * c), 2);
      check(w0, 16'h0000);
      check(w1, 16'h0000);
    end
    for (int c = 0; c < 4; c++) begin
      pulse(c, c != 3, c != 2, 28'hA5C_3E10 + 28'(c));
    end
    // Later channels keep their flags while earlier ones are read
    for (int c = 0; c < 4; c++) begin
      v = 28'hA5C_3E10 + 28'(c);
      get(8'(2 * c), 2);
      check(w0, {2'b00, c != 3, c != 2, v[27:16]});
      check(w1, v[15:0]);
      get(8'(2 * c), 1);
      check(w0, 16'h0A5C);
    end
    pulse(0, 1'b1, 1'b0, 28'h123_4567);
    get(8'h01, 1);
    check(w0, 16'h3E10);
    get(8'h00, 2);
    check(w0, 16'h2123);
    check(w1, 16'h4567);
    get(8'h08, 1);
    check(w0, 16'h0000);
    ta = crr_pkg::CRR_TARGET_ADDR_HIGH;
    get(8'h00, 1);
    check({15'h0000, ak}, 16'h0001);
    check(w0, 16'hFFFF);
    // Narrow variant at the high address: 12-bit result, lower word zero
    narrow_on <= 1'b1;
    get(8'h00, 2);
    check({15'h0000, ak}, 16'h0000);
    check(w0, 16'h3567);
    check(w1, 16'h0000);
    get(8'h00, 1);
    check(w0, 16'h0567);
    narrow_on <= 1'b0;
    addr_sel <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    get(8'h00, 1);
    check({15'h0000, ak}, 16'h0000);
    check(w0, 16'h0123);
    // Reset in mid-run: the live result reads zero in both words (the upper read reloads the hold)
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    get(8'h00, 2);
    check(w0, 16'h0000);
    check(w1, 16'h0000);
    wrap_up();
  end
endmodule // crr_result_regs_tb_top
